// ==== hdl/cmg_map.vh ====
// Constants for the crypto mode and self-test guard.
`ifndef CMG_MAP_VH
`define CMG_MAP_VH
// Register word indices (byte address is four times the index).
`define CMG_REG_CTRL 4'h0
`define CMG_REG_STATUS 4'h1
`define CMG_REG_KEY_APP 4'h2
`define CMG_REG_KEY_NAP 4'h3
`define CMG_REG_CTR 4'h4
// Control register field positions.
`define CMG_CTRL_REQ 0
`define CMG_CTRL_NONAPP 1
`define CMG_CTRL_CTR_LOAD 2
// Status register field positions.
`define CMG_ST_BUSY 0
`define CMG_ST_PASS 1
`define CMG_ST_LOCK 2
`define CMG_ST_NONAPP 3
`define CMG_ST_RESULT_OK 4
// Reset values.
`define CMG_KEY_RST 32'h0000_0000
`define CMG_CTR_RST 128'h0
// Number of algorithms checked at power-up.
`define CMG_NUM_ALGOS 7
// Cycles allowed for each known-answer check before the guard locks.
`define CMG_CHECK_CYCLES 16
`endif

// ==== hdl/cmg_buf2.v ====
// Two-entry valid/ready buffer for the payload path.
`timescale 1ns/1ps
module cmg_buf2
#(
   parameter WIDTH = 32
)
(
   // Clock and reset.
   input wire core_clk_i,
   input wire srst_i,
   // Fill side.
   input wire in_valid_i,
   output wire in_ready_o,
   input wire [WIDTH-1:0] in_data_i,
   // Drain side.
   output wire out_valid_o,
   input wire out_ready_i,
   output wire [WIDTH-1:0] out_data_o
);
   reg [WIDTH-1:0] mem_r [0:1];
   reg wr_ptr_r;
   reg rd_ptr_r;
   reg [1:0] count_r;
   wire push;
   wire pop;

   // Honest full and empty come straight from the fill count.
   assign in_ready_o = (count_r != 2'h2);
   assign out_valid_o = (count_r != 2'h0);
   assign out_data_o = mem_r[rd_ptr_r];
   assign push = in_valid_i && in_ready_o;
   assign pop = out_valid_o && out_ready_i;

   // Pointers and count; a push and a pop in one cycle leave the count alone.
   always @(posedge core_clk_i)
   begin
      if (srst_i)
      begin
         wr_ptr_r <= 1'b0;
         rd_ptr_r <= 1'b0;
         count_r <= 2'h0;
      end
      else
      begin
         if (push)
         begin
            mem_r[wr_ptr_r] <= in_data_i;
            wr_ptr_r <= ~wr_ptr_r;
         end
         if (pop)
            rd_ptr_r <= ~rd_ptr_r;
         if (push && !pop)
            count_r <= count_r + 2'h1;
         else if (pop && !push)
            count_r <= count_r - 2'h1;
      end
   end
endmodule // cmg_buf2

// ==== hdl/cmg_guard.v ====
// Mode, self-test and secret storage guard around the crypto datapath.
`timescale 1ns/1ps
`include "cmg_map.vh"
module cmg_guard
#(
   parameter WIDTH = 32,
   parameter NUM_ALGOS = `CMG_NUM_ALGOS,
   parameter CHECK_CYCLES = `CMG_CHECK_CYCLES
)
(
   // Clock and reset.
   input wire core_clk_i,
   input wire srst_i,
   // Register port.
   input wire reg_wr_i,
   input wire reg_rd_i,
   input wire [3:0] reg_idx_i,
   input wire [31:0] reg_wdata_i,
   output reg [31:0] reg_rdata_o,
   // Known-answer check engine.
   output reg check_start_o,
   output reg [3:0] check_algo_o,
   input wire check_done_i,
   input wire check_pass_i,
   // Datapath key and counter.
   output reg [31:0] active_key_o,
   output reg [127:0] ctr_o,
   // Payload input FIFO, filled by the host DMA.
   input wire din_valid_i,
   output reg din_ready_o,
   input wire din_pipe_i,
   input wire [WIDTH-1:0] din_data_i,
   // Processed result from the datapath.
   input wire res_valid_i,
   input wire [WIDTH-1:0] res_data_i,
   output reg res_ready_o,
   // Payload to the datapath.
   output reg core_valid_o,
   output reg [WIDTH-1:0] core_data_o,
   input wire core_ready_i,
   // Payload output FIFO, drained by the host DMA.
   output reg dout_valid_o,
   output reg [WIDTH-1:0] dout_data_o,
   input wire dout_ready_i
);
   // One-hot states.
   localparam ST_CHECK = 5'h01;
   localparam ST_WAIT = 5'h02;
   localparam ST_APPR = 5'h04;
   localparam ST_NONAPP = 5'h08;
   localparam ST_LOCK = 5'h10;

   reg [4:0] state_r;
   reg [3:0] algo_r;
   reg [7:0] wait_r;
   reg pass_r;
   reg [31:0] key_app_r;
   reg [31:0] key_nap_r;
   reg [127:0] ctr_r;
   reg served_ok_r;
   wire services_on;
   wire buf_in_ready;
   wire buf_out_valid;
   wire [WIDTH-1:0] buf_out_data;
   wire din_push;
   wire buf_pop;
   wire res_take;
   wire dout_nxt;

   // Wrapping increment kept as a function so the counter cannot saturate.
   function [127:0] ctr_inc;
      input [127:0] c;
      begin
         ctr_inc = c + 128'h1;
      end
   endfunction

   // Services exist only in a mode state, never while checking or locked.
   assign services_on = (state_r == ST_APPR) || (state_r == ST_NONAPP);
   // Pipe 1 belongs to non-approved work, pipe 0 to approved; a word on the other mode's pipe is dropped on the floor.
   assign din_push = din_valid_i && services_on &&
      (din_pipe_i == (state_r == ST_NONAPP));
   assign buf_pop = buf_out_valid && core_ready_i && !core_valid_o;
   // Next output valid; a result is taken only into an empty output word.
   // This halves the result rate, but a stalled host can never lose a word.
   assign res_take = res_valid_i && res_ready_o;
   assign dout_nxt = (res_take && services_on) || (dout_valid_o && !dout_ready_i);

   // Input buffer absorbs a datapath stall so no payload word is lost.
   cmg_buf2 #(.WIDTH(WIDTH)) u_inbuf
   (
      .core_clk_i(core_clk_i),
      .srst_i(srst_i),
      .in_valid_i(din_push),
      .in_ready_o(buf_in_ready),
      .in_data_i(din_data_i),
      .out_valid_o(buf_out_valid),
      .out_ready_i(buf_pop),
      .out_data_o(buf_out_data)
   );

   // Self-test sequencer and mode control; a locked guard waits for reset.
   always @(posedge core_clk_i)
   begin
      if (srst_i)
      begin
         state_r <= ST_CHECK;
         algo_r <= 4'h0;
         wait_r <= 8'h0;
         pass_r <= 1'b0;
         check_start_o <= 1'b0;
         check_algo_o <= 4'h0;
      end
      else
      begin
         check_start_o <= 1'b0;
         case (state_r)
            ST_CHECK:
            begin
               check_start_o <= 1'b1;
               check_algo_o <= algo_r;
               wait_r <= 8'h0;
               state_r <= ST_WAIT;
            end
            ST_WAIT:
            begin
               wait_r <= wait_r + 8'h1;
               if (check_done_i && !check_pass_i)
                  state_r <= ST_LOCK;
               else if (check_done_i && algo_r == NUM_ALGOS - 1)
               begin
                  pass_r <= 1'b1;
                  state_r <= ST_APPR;
               end
               else if (check_done_i)
               begin
                  algo_r <= algo_r + 4'h1;
                  state_r <= ST_CHECK;
               end
               else if (wait_r == CHECK_CYCLES[7:0])
                  state_r <= ST_LOCK;
            end
            ST_APPR:
               if (reg_wr_i && reg_idx_i == `CMG_REG_CTRL &&
                   reg_wdata_i[`CMG_CTRL_REQ] && reg_wdata_i[`CMG_CTRL_NONAPP])
                  state_r <= ST_NONAPP;
            ST_NONAPP:
               if (res_valid_i && res_ready_o)
                  state_r <= ST_APPR;
            ST_LOCK:
               state_r <= ST_LOCK;
            default:
               state_r <= ST_LOCK;
         endcase
      end
   end

   // Write-only secret stores, one per mode, cleared by reset.
   always @(posedge core_clk_i)
   begin
      if (srst_i)
      begin
         key_app_r <= `CMG_KEY_RST;
         key_nap_r <= `CMG_KEY_RST;
         ctr_r <= `CMG_CTR_RST;
         active_key_o <= `CMG_KEY_RST;
      end
      else
      begin
         if (reg_wr_i && reg_idx_i == `CMG_REG_KEY_APP)
            key_app_r <= reg_wdata_i;
         if (reg_wr_i && reg_idx_i == `CMG_REG_KEY_NAP)
            key_nap_r <= reg_wdata_i;
         if (reg_wr_i && reg_idx_i == `CMG_REG_CTRL && reg_wdata_i[`CMG_CTRL_CTR_LOAD])
            ctr_r <= `CMG_CTR_RST;
         else if (buf_pop)
            ctr_r <= ctr_inc(ctr_r);
         // The datapath sees only the key of the current mode, zero otherwise.
         if (state_r == ST_APPR)
            active_key_o <= key_app_r;
         else if (state_r == ST_NONAPP)
            active_key_o <= key_nap_r;
         else
            active_key_o <= `CMG_KEY_RST;
      end
   end

   // Payload path; the output takes only processed words, never raw input.
   always @(posedge core_clk_i)
   begin
      if (srst_i)
      begin
         din_ready_o <= 1'b0;
         core_valid_o <= 1'b0;
         core_data_o <= {WIDTH{1'b0}};
         res_ready_o <= 1'b0;
         dout_valid_o <= 1'b0;
         dout_data_o <= {WIDTH{1'b0}};
         ctr_o <= `CMG_CTR_RST;
         served_ok_r <= 1'b0;
      end
      else
      begin
         // Ready drops for a cycle after each push, so a ready seen high always has room.
         din_ready_o <= buf_in_ready && services_on && !din_push;
         ctr_o <= ctr_r;
         if (buf_pop)
         begin
            core_valid_o <= 1'b1;
            core_data_o <= buf_out_data;
         end
         else if (core_ready_i)
            core_valid_o <= 1'b0;
         res_ready_o <= !dout_nxt;
         if (res_valid_i && res_ready_o && services_on)
         begin
            dout_valid_o <= 1'b1;
            dout_data_o <= res_data_i;
            served_ok_r <= 1'b1;
         end
         else if (dout_ready_i)
            dout_valid_o <= 1'b0;
      end
   end

   // Register reads; secrets read as zero and status carries no key bits.
   always @(posedge core_clk_i)
   begin
      if (srst_i)
         reg_rdata_o <= 32'h0000_0000;
      else if (reg_rd_i)
      begin
         reg_rdata_o <= 32'h0000_0000;
         if (reg_idx_i == `CMG_REG_STATUS)
         begin
            reg_rdata_o[`CMG_ST_BUSY] <= (state_r == ST_CHECK) || (state_r == ST_WAIT);
            reg_rdata_o[`CMG_ST_PASS] <= pass_r && (state_r != ST_LOCK);
            reg_rdata_o[`CMG_ST_LOCK] <= (state_r == ST_LOCK);
            reg_rdata_o[`CMG_ST_NONAPP] <= (state_r == ST_NONAPP);
            reg_rdata_o[`CMG_ST_RESULT_OK] <= served_ok_r;
         end
      end
   end
endmodule // cmg_guard

// ==== sim/cmg_guard_monitor.sv ====
// Port checks for the mode and self-test guard.
`timescale 1ns/1ps
module cmg_guard_monitor
(
   // Clock and reset.
   input wire core_clk_i,
   input wire srst_i,
   // Register and check ports.
   input wire reg_rd_i,
   input wire [3:0] reg_idx_i,
   input wire [31:0] reg_rdata_o,
   input wire check_start_o,
   input wire [3:0] check_algo_o,
   input wire check_done_i,
   input wire check_pass_i,
   // Key, counter and payload.
   input wire [31:0] active_key_o,
   input wire [127:0] ctr_o,
   input wire din_ready_o,
   input wire core_valid_o,
   input wire [31:0] core_data_o,
   input wire core_ready_i,
   input wire res_valid_i,
   input wire res_ready_o,
   input wire dout_valid_o
);
   // One domain, so clock and reset are given once.
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (srst_i);
   a_secret_read_zero: assert property (reg_rd_i && reg_idx_i inside {[4'h2:4'h4]} |=> reg_rdata_o == 32'h0)
      else $error("secret read not zero");
   a_reset_zeroize: assert property ($fell(srst_i) |-> active_key_o == 32'h0 && ctr_o == 128'h0)
      else $error("secret kept over reset");
   a_first_check: assert property ($fell(srst_i) |=> check_start_o && check_algo_o == 4'h0)
      else $error("checks not started");
   a_fail_locks: assert property (check_done_i && !check_pass_i |=> (!check_start_o && !din_ready_o) [*8])
      else $error("service after failed check");
   a_start_pulse: assert property (check_start_o |=> !check_start_o)
      else $error("check start not a pulse");
   a_ctr_steps: assert property ($changed(ctr_o) |-> ctr_o == $past(ctr_o) + 128'h1 || ctr_o == 128'h0)
      else $error("counter jumped");
   a_core_hold: assert property (core_valid_o && !core_ready_i |=> core_valid_o && $stable(core_data_o))
      else $error("core word dropped");
   a_out_cause: assert property ($rose(dout_valid_o) |-> $past(res_valid_i && res_ready_o))
      else $error("output without result");
endmodule // cmg_guard_monitor

// ==== sim/cmg_far_model.sv ====
// Check engine and datapath that sit beyond the guard.
`timescale 1ns/1ps
module cmg_far_model
(
   // Clock, reset and check verdict.
   input wire core_clk_i,
   input wire srst_i,
   input wire pass_en_i,
   // Check engine.
   input wire check_start_i,
   output reg check_done_o,
   output wire check_pass_o,
   // Datapath.
   input wire core_valid_i,
   input wire [31:0] core_data_i,
   output wire core_ready_o,
   output wire res_valid_o,
   output wire [31:0] res_data_o,
   input wire res_ready_i
);
   reg [1:0] wait_r;
   reg full_r;
   reg [31:0] res_r;
   // An idle result bus shows the inverse word, so stale data never looks valid.
   assign core_ready_o = !full_r;
   assign res_valid_o = full_r;
   assign res_data_o = full_r ? res_r : ~res_r;
   assign check_pass_o = pass_en_i;
   // Checks answer three cycles after start; a held result stalls the next word.
   always @(posedge core_clk_i)
   begin
      check_done_o <= 1'b0;
      if (srst_i)
      begin
         wait_r <= 2'h0;
         full_r <= 1'b0;
         res_r <= 32'h0;
      end
      else
      begin
         if (check_start_i)
            wait_r <= 2'h2;
         else if (wait_r != 2'h0)
         begin
            wait_r <= wait_r - 2'h1;
            check_done_o <= (wait_r == 2'h1);
         end
         if (core_valid_i && !full_r)
         begin
            full_r <= 1'b1;
            res_r <= core_data_i ^ 32'ha5a5_a5a5;
         end
         else if (res_ready_i)
            full_r <= 1'b0;
      end
   end
endmodule // cmg_far_model

// ==== sim/tb.sv ====
// Self-checking bench for the mode and self-test guard.
`timescale 1ns/1ps
module tb;
   reg core_clk_i = 1'b0;
   reg srst_i = 1'b1;
   reg reg_wr_i = 1'b0;
   reg reg_rd_i = 1'b0;
   reg [3:0] reg_idx_i = 4'h0;
   reg [31:0] reg_wdata_i = 32'h0;
   reg din_valid_i = 1'b0;
   reg din_pipe_i = 1'b0;
   reg [31:0] din_data_i = 32'h0;
   reg dout_ready_i = 1'b1;
   reg pass_en = 1'b1;
   wire [31:0] reg_rdata_o, active_key_o, core_data_o, dout_data_o, res_data_i;
   wire [127:0] ctr_o;
   wire [3:0] check_algo_o;
   wire check_start_o, check_done_i, check_pass_i, din_ready_o, res_valid_i, res_ready_o;
   wire core_valid_o, core_ready_i, dout_valid_o;
   integer fail_count = 0;
   integer n_checks = 0;
   integer n;
   reg [31:0] rv;
   // Short check counts keep the power-up sequence brief.
   always #25 core_clk_i = ~core_clk_i;
   cmg_guard #(.NUM_ALGOS(2), .CHECK_CYCLES(4)) u_cmg_guard (.*);
   cmg_far_model u_cmg_far_model (.core_clk_i(core_clk_i), .srst_i(srst_i), .pass_en_i(pass_en),
      .check_start_i(check_start_o), .check_done_o(check_done_i), .check_pass_o(check_pass_i),
      .core_valid_i(core_valid_o), .core_data_i(core_data_o), .core_ready_o(core_ready_i),
      .res_valid_o(res_valid_i), .res_data_o(res_data_i), .res_ready_i(res_ready_o));
   // Compare and count.
   task chk(input [95:0] what, input [31:0] seen, input [31:0] exp);
   begin
      n_checks = n_checks + 1;
      if (seen !== exp)
      begin
         fail_count = fail_count + 1;
         $display("mismatch %0s expected %h seen %h", what, exp, seen);
      end
   end
   endtask
   task test_done;
   begin
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   end
   endtask
   // A wait that runs out counts as a failure and ends the run at once.
   task limit(input ok);
   begin
      if (!ok)
      begin
         chk("timeout", 32'h0, 32'h1);
         test_done;
      end
   end
   endtask
   // Register write and read; read data lands one cycle after the strobe.
   task wr(input [3:0] i, input [31:0] d);
   begin
      reg_wr_i <= 1'b1;
      reg_idx_i <= i;
      reg_wdata_i <= d;
      @(posedge core_clk_i);
      reg_wr_i <= 1'b0;
      @(posedge core_clk_i);
   end
   endtask
   task rd(input [3:0] i);
   begin
      reg_rd_i <= 1'b1;
      reg_idx_i <= i;
      @(posedge core_clk_i);
      reg_rd_i <= 1'b0;
      @(posedge core_clk_i);
      rv = reg_rdata_o;
   end
   endtask
   // Reset, then poll status until checks settle.
   task boot(input p);
   begin
      pass_en <= p;
      srst_i <= 1'b1;
      repeat (6) @(posedge core_clk_i);
      srst_i <= 1'b0;
      rd(4'h1);
      chk("busy", rv & 32'h7, 32'h1);
      for (n = 0; n < 40 && rv[2:1] == 2'b00; n = n + 1)
         rd(4'h1);
      limit(rv[2:1] != 2'b00);
   end
   endtask
   // Valid is raised only while the buffer shows space.
   task send(input p, input [31:0] d);
   begin
      for (n = 0; n < 40 && din_ready_o !== 1'b1; n = n + 1)
         @(posedge core_clk_i);
      limit(din_ready_o === 1'b1);
      din_valid_i <= 1'b1;
      din_pipe_i <= p;
      din_data_i <= d;
      @(posedge core_clk_i);
      din_valid_i <= 1'b0;
      @(posedge core_clk_i);
   end
   endtask
   // The word is taken at the edge where valid is seen while ready is held high.
   task get(input [31:0] d);
   begin
      dout_ready_i <= 1'b1;
      @(posedge core_clk_i);
      for (n = 0; n < 40 && dout_valid_o !== 1'b1; n = n + 1)
         @(posedge core_clk_i);
      limit(dout_valid_o === 1'b1);
      chk("dout", dout_data_o, d ^ 32'ha5a5_a5a5);
   end
   endtask
   task s_keys;
   begin
      boot(1'b1);
      chk("status", rv & 32'h1f, 32'h2);
      wr(4'h2, 32'h1234_5678);
      wr(4'h3, 32'h0bad_f00d);
      rd(4'h2);
      chk("key_app", rv, 32'h0);
      rd(4'h3);
      chk("key_nap", rv, 32'h0);
      rd(4'hf);
      chk("unmapped", rv, 32'h0);
      chk("act_key", active_key_o, 32'h1234_5678);
   end
   endtask
   task s_data;
   begin
      wr(4'h0, 32'h4);
      dout_ready_i <= 1'b0;
      send(1'b0, 32'h0000_0011);
      send(1'b0, 32'h0000_0022);
      send(1'b1, 32'h0000_0033);
      get(32'h0000_0011);
      get(32'h0000_0022);
      repeat (10) @(posedge core_clk_i);
      chk("dropped", {31'h0, dout_valid_o}, 32'h0);
      chk("ctr", ctr_o[31:0], 32'h2);
   end
   endtask
   task s_nonapp;
   begin
      wr(4'h3, 32'h0fee_d000);
      wr(4'h0, 32'h3);
      rd(4'h1);
      chk("st_nap", rv & 32'h8, 32'h8);
      chk("nap_key", active_key_o, 32'h0fee_d000);
      send(1'b1, 32'h0000_0044);
      get(32'h0000_0044);
      rd(4'h1);
      chk("st_app", rv & 32'h8, 32'h0);
   end
   endtask
   task s_lock;
   begin
      boot(1'b0);
      chk("st_lock", rv & 32'h6, 32'h4);
      chk("lock_rdy", {31'h0, din_ready_o}, 32'h0);
      boot(1'b1);
      chk("st_again", rv & 32'h6, 32'h2);
      chk("zeroed", active_key_o, 32'h0);
   end
   endtask
   initial
   begin
      s_keys;
      s_data;
      s_nonapp;
      s_lock;
      test_done;
   end
endmodule // tb
bind cmg_guard cmg_guard_monitor u_cmg_guard_monitor (.*);
